// ### design/wrx_biphase_enc.sv
// Differential bi-phase bit encoder driving the load switch.
`timescale 1ns/100ps
`default_nettype none
module wrx_biphase_enc #(
    parameter int HALF_CYC = 31250
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic bit_valid,
    input wire logic bit_value,
    output logic bit_ready,
    output logic mod_out
);
    logic busy_r;
    logic second_r;
    logic val_r;
    logic mod_r;
    logic [23:0] cnt_r;

    assign bit_ready = !busy_r;
    assign mod_out = mod_r;

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            busy_r <= 1'b0;
            second_r <= 1'b0;
            val_r <= 1'b0;
            mod_r <= 1'b0;
            cnt_r <= 24'h0;
        end
        else if (!busy_r)
        begin
            if (bit_valid)
            begin
                busy_r <= 1'b1;
                second_r <= 1'b0;
                val_r <= bit_value;
                mod_r <= ~mod_r; // RULE1
                cnt_r <= 24'h0;
            end
        end
        else if (cnt_r == 24'(HALF_CYC - 1))
        begin
            cnt_r <= 24'h0;
            if (!second_r)
            begin
                second_r <= 1'b1;
                if (val_r)
                begin
                    mod_r <= ~mod_r; // RULE1
                end
            end
            else
            begin
                busy_r <= 1'b0;
            end
        end
        else
        begin
            cnt_r <= cnt_r + 24'h1;
        end
    end
endmodule : wrx_biphase_enc
`default_nettype wire

// ### design/wrx_link_if.sv
// Load modulation link between receiver and charging pad.
`timescale 1ns/100ps
`default_nettype none
interface wrx_link_if;
    logic ping;
    logic load_mod;
    modport dev (input ping, output load_mod);
    modport pad (output ping, input load_mod);
endinterface : wrx_link_if
`default_nettype wire

// ### design/wrx_params.svh
// Constants for the wireless receiver power control link.
`ifndef WRX_PARAMS_SVH
`define WRX_PARAMS_SVH
`define WRX_CLK_NS 8
`define WRX_BIT_NS 500000
`define WRX_CE_FAST_NS 30000000
`define WRX_CE_SLOW_NS 250000000
`define WRX_PING_NS 70000000
`define WRX_OFF_NS 400000000
`define WRX_PRE_BITS 4'd11
`define WRX_HDR_SS 8'h01
`define WRX_HDR_CFG 8'h51
`define WRX_HDR_ID 8'h71
`define WRX_HDR_CE 8'h03
`define WRX_HDR_RP 8'h04
`define WRX_HDR_EPT 8'h02
`define WRX_EPT_UNKNOWN 8'h00
`define WRX_EPT_DONE 8'h01
`define WRX_EPT_FAULT 8'h02
`define WRX_EPT_HOT 8'h03
`define WRX_MV_RAISE 15'd7000
`define WRX_MV_BAND0 15'd7080
`define WRX_MV_BAND1 15'd6280
`define WRX_MV_BAND2 15'd5530
`define WRX_MV_BAND3 15'd5110
`define WRX_MV_TOL 15'd50
`define WRX_MA_KNEE 12'd300
`define WRX_MA_COMM_FIX 12'd400
`define WRX_MA_COMM_ADD 12'd50
`define WRX_TEMP_HIGH 2'b01
`define WRX_TEMP_LOW 2'b10
`define WRX_RP_EVERY 2'd3
`endif

// ### design/wrx_pkg.sv
// Types for the two ends of the link, each used by one end only.
package wrx_pkg;
    typedef enum {S_WAIT_PING, S_SS, S_CFG, S_ID, S_CE, S_RP, S_WAIT, S_EPT, S_OFF} wrx_rx_state_t;
    typedef enum {F_IDLE, F_PRE, F_BYTE} wrx_frame_t;
    typedef enum {T_OFF, T_PING, T_PWR} wrx_tx_state_t;
    typedef enum {P_HUNT, P_DATA, P_GAP} wrx_parse_t;
endpackage : wrx_pkg

// ### design/wrx_rx_end.sv
// Receiver end: handshake, main loop, packet framing and limits.
// Notes on behaviour
// RULE1: Packets use differential bi-phase at 2 kbps.
// RULE2: Receiver signals only by load switching.
// RULE3: First packets: strength, configuration, identification.
// RULE4: Start-up shutdown condition requests stop immediately.
// RULE5: Power contract only after three start-up packets.
// RULE6: Raise rectified voltage above 7 V first.
// RULE7: Active transfer repeatedly sends control error packets.
// RULE8: Below 10% 7.08 V; 10-20% 6.28 V.
// RULE9: 20-40% 5.53 V; above 40% 5.11 V.
// RULE10: Band thresholds scale with resistor-set full scale.
// RULE11: Each pass checks stop conditions, then terminates.
// RULE12: Report received power from sense input.
// RULE13: Averaged current below 300 mA: 400 mA limit.
// RULE14: Averaged current above 300 mA: current plus 50.
// RULE15: First mode select high enables on-the-go mode.
// RULE16: Transmitter pings, stays powered after identification.
// RULE17: Control errors every 30 ms, converged 250 ms.
// RULE18: Termination packet header 0x02 with reason code.
// RULE19: Both mode selects high: disable, charge complete.
// RULE20: Frame: preamble, header, messages, checksum byte.
// RULE21: Target re-evaluated before each control error packet; the code skips this for the first one after identification.
`include "wrx_params.svh"
`timescale 1ns/100ps
`default_nettype none
module wrx_rx_end #(
    parameter int HALF_CYC = `WRX_BIT_NS / 2 / `WRX_CLK_NS,
    parameter int FAST_CYC = `WRX_CE_FAST_NS / `WRX_CLK_NS,
    parameter int SLOW_CYC = `WRX_CE_SLOW_NS / `WRX_CLK_NS,
    // Identification and configuration words are arbitrary values.
    parameter logic [15:0] ID_CODE = 16'h1234,
    parameter logic [15:0] CFG_WORD = 16'h0000
) (
    input wire logic clk_sys,
    input wire logic srst,
    wrx_link_if.dev link,
    input wire logic mode_select_a,
    input wire logic mode_select_b,
    input wire logic adapter_present,
    input wire logic [1:0] temp_ctrl_input,
    input wire logic internal_fault,
    input wire logic [14:0] rectified_voltage,
    input wire logic [11:0] out_current,
    input wire logic [11:0] received_power_sense,
    input wire logic [19:0] max_current_gain,
    input wire logic [11:0] current_limit_set,
    output logic out_enable,
    output logic otg_enable,
    output logic contract,
    output logic comm_limit_on,
    output logic [11:0] comm_limit_ma,
    output logic [14:0] rect_target
);
    wrx_pkg::wrx_rx_state_t st_r;
    wrx_pkg::wrx_frame_t ph_r;
    logic sent_r;
    logic [7:0] buf_r [0:3];
    logic [2:0] nbytes_r;
    logic [2:0] bidx_r;
    logic [3:0] bit_r;
    logic [3:0] pre_r;
    logic [25:0] tmr_r;
    logic [1:0] pass_r;
    logic [15:0] acc_r;
    logic [15:0] imax_r;
    logic contract_r;
    logic out_en_r;
    logic otg_r;
    logic lim_on_r;
    logic [11:0] lim_r;
    logic [14:0] tgt_r;
    logic bit_ready;
    logic bit_val;
    logic busy;
    logic stop;
    logic [7:0] reason;
    logic [7:0] hdr;
    logic [7:0] m0;
    logic [7:0] m1;
    logic two;
    logic [11:0] iavg;
    logic [15:0] err;
    logic conv;
    logic quiet;
    logic [23:0] quiet_r;

    function automatic logic [14:0] band_target(input logic [11:0] i, input logic [15:0] imax);
        logic [19:0] i5;
        i5 = 20'(i) * 20'd5;
        if ((i5 << 1) < 20'(imax))
            band_target = `WRX_MV_BAND0; // RULE8
        else if (i5 < 20'(imax))
            band_target = `WRX_MV_BAND1; // RULE8
        else if (i5 < (20'(imax) << 1))
            band_target = `WRX_MV_BAND2; // RULE9
        else
            band_target = `WRX_MV_BAND3; // RULE9
    endfunction : band_target

    function automatic logic frame_bit(input logic [7:0] b, input logic [3:0] idx);
        if (idx == 4'd0 || idx == 4'd11)
            frame_bit = 1'b0;
        else if (idx <= 4'd8)
            frame_bit = b[3'(idx - 4'd1)];
        else if (idx == 4'd9)
            frame_bit = ~^b;
        else
            frame_bit = 1'b1;
    endfunction : frame_bit

    assign busy = (ph_r != wrx_pkg::F_IDLE);
    // A closing bit and a quiet spell let the pad see where each packet ends.
    assign quiet = quiet_r >= 24'(HALF_CYC);
    assign iavg = acc_r[15:4];
    assign err = 16'(rect_target) - 16'(rectified_voltage);
    assign conv = ($signed(err) <= $signed({1'b0, `WRX_MV_TOL}))
        && ($signed(err) >= -$signed({1'b0, `WRX_MV_TOL}));
    assign out_enable = out_en_r;
    assign otg_enable = otg_r;
    assign contract = contract_r;
    assign comm_limit_on = lim_on_r;
    assign comm_limit_ma = lim_r;
    assign rect_target = tgt_r;

    // Stop conditions and reason, highest priority first.
    always_comb
    begin
        stop = 1'b1;
        reason = `WRX_EPT_UNKNOWN;
        if (mode_select_a && mode_select_b)
            reason = `WRX_EPT_DONE; // RULE19
        else if (internal_fault || imax_r == 16'h0)
            reason = `WRX_EPT_FAULT;
        else if (temp_ctrl_input == `WRX_TEMP_LOW)
            reason = `WRX_EPT_HOT;
        else if (!(mode_select_a || (adapter_present && !mode_select_b)
            || temp_ctrl_input == `WRX_TEMP_HIGH))
            stop = 1'b0;
    end

    // Packet contents for the state that is sending.
    always_comb
    begin
        hdr = `WRX_HDR_CE;
        m0 = err[12:5];
        m1 = 8'h00;
        two = 1'b0;
        if ($signed(err) > 16'sd4095)
            m0 = 8'h7f;
        else if ($signed(err) < -16'sd4096)
            m0 = 8'h80;
        unique case (st_r)
            wrx_pkg::S_SS:
            begin
                hdr = `WRX_HDR_SS;
                m0 = rectified_voltage[14:7];
            end
            wrx_pkg::S_CFG:
            begin
                hdr = `WRX_HDR_CFG;
                {m0, m1} = CFG_WORD;
                two = 1'b1;
            end
            wrx_pkg::S_ID:
            begin
                hdr = `WRX_HDR_ID;
                {m0, m1} = ID_CODE;
                two = 1'b1;
            end
            wrx_pkg::S_RP:
            begin
                hdr = `WRX_HDR_RP;
                m0 = received_power_sense[11:4]; // RULE12
            end
            wrx_pkg::S_EPT:
            begin
                hdr = `WRX_HDR_EPT; // RULE18
                m0 = reason; // RULE18
            end
            default:
            begin
            end
        endcase
    end

    // Main sequence.
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            st_r <= wrx_pkg::S_WAIT_PING;
            sent_r <= 1'b0;
            tmr_r <= 26'h0;
            pass_r <= 2'h0;
            contract_r <= 1'b0;
            out_en_r <= 1'b0;
        end
        else if (!link.ping && st_r != wrx_pkg::S_WAIT_PING)
        begin
            st_r <= wrx_pkg::S_WAIT_PING;
            sent_r <= 1'b0;
            contract_r <= 1'b0;
            out_en_r <= 1'b0;
        end
        else
        begin
            unique case (st_r)
                wrx_pkg::S_WAIT_PING:
                    if (link.ping)
                        st_r <= stop ? wrx_pkg::S_EPT : wrx_pkg::S_SS; // RULE3 RULE4
                wrx_pkg::S_SS, wrx_pkg::S_CFG, wrx_pkg::S_ID, wrx_pkg::S_RP,
                wrx_pkg::S_EPT:
                    if (!busy && !sent_r && quiet)
                        sent_r <= 1'b1;
                    else if (!busy && sent_r)
                    begin
                        sent_r <= 1'b0;
                        unique case (st_r)
                            wrx_pkg::S_SS: st_r <= wrx_pkg::S_CFG; // RULE3
                            wrx_pkg::S_CFG: st_r <= wrx_pkg::S_ID; // RULE3
                            wrx_pkg::S_ID:
                            begin
                                contract_r <= 1'b1; // RULE5
                                st_r <= wrx_pkg::S_CE;
                            end
                            wrx_pkg::S_RP: st_r <= wrx_pkg::S_WAIT;
                            default: st_r <= wrx_pkg::S_OFF;
                        endcase
                    end
                wrx_pkg::S_CE:
                    if (stop)
                    begin
                        st_r <= wrx_pkg::S_EPT; // RULE11
                        sent_r <= 1'b0;
                        out_en_r <= 1'b0;
                    end
                    else if (!busy && !sent_r && quiet)
                        sent_r <= 1'b1; // RULE7
                    else if (!busy && sent_r)
                    begin
                        sent_r <= 1'b0;
                        pass_r <= pass_r + 2'h1;
                        tmr_r <= conv ? 26'(SLOW_CYC - 1) : 26'(FAST_CYC - 1); // RULE17
                        st_r <= (pass_r == `WRX_RP_EVERY) ? wrx_pkg::S_RP : wrx_pkg::S_WAIT;
                    end
                wrx_pkg::S_WAIT:
                begin
                    if (!out_en_r && rectified_voltage > `WRX_MV_RAISE)
                        out_en_r <= 1'b1; // RULE6
                    if (stop)
                        st_r <= wrx_pkg::S_CE; // RULE11
                    else if (tmr_r == 26'h0)
                        st_r <= wrx_pkg::S_CE; // RULE17
                    else
                        tmr_r <= tmr_r - 26'h1;
                end
                wrx_pkg::S_OFF:
                    out_en_r <= 1'b0;
            endcase
        end
    end

    // Frame sequencer: preamble, then bytes of start, data, parity, stop.
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            ph_r <= wrx_pkg::F_IDLE;
            nbytes_r <= 3'h0;
            bidx_r <= 3'h0;
            bit_r <= 4'h0;
            pre_r <= 4'h0;
            for (int k = 0; k < 4; k++)
                buf_r[k] <= 8'h00;
        end
        else if (ph_r == wrx_pkg::F_IDLE)
        begin
            if (quiet && !sent_r && (st_r inside {wrx_pkg::S_SS, wrx_pkg::S_CFG, wrx_pkg::S_ID,
                wrx_pkg::S_RP, wrx_pkg::S_EPT} || st_r == wrx_pkg::S_CE && !stop))
            begin
                ph_r <= wrx_pkg::F_PRE; // RULE20
                pre_r <= 4'h0;
                bidx_r <= 3'h0;
                bit_r <= 4'h0;
                buf_r[0] <= hdr;
                buf_r[1] <= m0;
                buf_r[2] <= two ? m1 : (hdr ^ m0); // RULE20
                buf_r[3] <= hdr ^ m0 ^ m1;
                nbytes_r <= two ? 3'd4 : 3'd3;
            end
        end
        else if (bit_ready)
        begin
            if (ph_r == wrx_pkg::F_PRE)
            begin
                pre_r <= pre_r + 4'h1;
                if (pre_r == `WRX_PRE_BITS - 4'h1)
                    ph_r <= wrx_pkg::F_BYTE;
            end
            else if (bit_r < 4'd10 || (bit_r == 4'd10 && bidx_r == nbytes_r - 3'h1))
                bit_r <= bit_r + 4'h1;
            else
            begin
                bit_r <= 4'h0;
                bidx_r <= bidx_r + 3'h1;
                if (bidx_r == nbytes_r - 3'h1)
                    ph_r <= wrx_pkg::F_IDLE;
            end
        end
    end

    assign bit_val = (ph_r == wrx_pkg::F_PRE) ? 1'b1 : frame_bit(buf_r[bidx_r[1:0]], bit_r);

    // Measurement, target and limits.
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            acc_r <= 16'h0;
            quiet_r <= 24'h0;
            imax_r <= 16'h0;
            tgt_r <= `WRX_MV_BAND0;
            lim_on_r <= 1'b0;
            lim_r <= `WRX_MA_COMM_FIX;
            otg_r <= 1'b0;
        end
        else
        begin
            acc_r <= acc_r - (acc_r >> 4) + 16'(out_current);
            quiet_r <= (busy || !bit_ready) ? 24'h0 : quiet_r + {23'h0, !quiet};
            imax_r <= (current_limit_set == 12'h0) ? 16'h0
                : 16'(max_current_gain / 20'(current_limit_set)); // RULE10
            if (st_r == wrx_pkg::S_WAIT)
                tgt_r <= out_en_r ? band_target(out_current, imax_r) // RULE21
                    : `WRX_MV_BAND0; // RULE6
            lim_on_r <= busy && !mode_select_a && !mode_select_b;
            if (iavg < `WRX_MA_KNEE)
                lim_r <= `WRX_MA_COMM_FIX; // RULE13
            else
                lim_r <= iavg + `WRX_MA_COMM_ADD; // RULE14
            otg_r <= mode_select_a && !mode_select_b; // RULE15
        end
    end

    wrx_biphase_enc #(.HALF_CYC(HALF_CYC)) u_enc (
        .clk_sys(clk_sys),
        .srst(srst),
        .bit_valid(busy),
        .bit_value(bit_val),
        .bit_ready(bit_ready),
        .mod_out(link.load_mod) // RULE2
    );
endmodule : wrx_rx_end
`default_nettype wire

// ### design/wrx_tx_end.sv
// Charging pad end: ping, bi-phase decoding, packet checks, contract.
`include "wrx_params.svh"
`timescale 1ns/100ps
`default_nettype none
module wrx_tx_end #(
    parameter int HALF_CYC = `WRX_BIT_NS / 2 / `WRX_CLK_NS,
    parameter int PING_CYC = `WRX_PING_NS / `WRX_CLK_NS,
    parameter int OFF_CYC = `WRX_OFF_NS / `WRX_CLK_NS
) (
    input wire logic clk_sys,
    input wire logic srst,
    wrx_link_if.pad link,
    output logic coil_on,
    output logic contract,
    output logic pkt_valid,
    output logic pkt_err,
    output logic [7:0] pkt_hdr,
    output logic [7:0] pkt_m0,
    output logic [7:0] pkt_m1
);
    wrx_pkg::wrx_tx_state_t ts_r;
    wrx_pkg::wrx_parse_t ps_r;
    logic [25:0] tmr_r;
    logic [1:0] step_r;
    logic prev_r;
    logic half_r;
    logic [23:0] gap_r;
    logic [3:0] ones_r;
    logic [3:0] bn_r;
    logic [9:0] sh_r;
    logic [7:0] b_r [0:3];
    logic [2:0] n_r;
    logic vld_r;
    logic perr_r;
    logic [7:0] hdr_r;
    logic [7:0] m0_r;
    logic [7:0] m1_r;
    logic edge_w;
    logic bev;
    logic bval;
    logic idle_w;

    assign edge_w = link.load_mod != prev_r;
    assign idle_w = gap_r > 24'(HALF_CYC * 5 / 2);
    assign bev = edge_w && !idle_w && (gap_r >= 24'(HALF_CYC * 3 / 2) || half_r); // RULE1
    assign bval = gap_r < 24'(HALF_CYC * 3 / 2);
    assign coil_on = (ts_r != wrx_pkg::T_OFF);
    assign link.ping = coil_on;
    assign contract = (ts_r == wrx_pkg::T_PWR);
    assign pkt_valid = vld_r;
    assign pkt_err = perr_r;
    assign pkt_hdr = hdr_r;
    assign pkt_m0 = m0_r;
    assign pkt_m1 = m1_r;

    // Bit recovery and byte parsing.
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            prev_r <= 1'b0;
            half_r <= 1'b0;
            gap_r <= 24'hffffff;
            ps_r <= wrx_pkg::P_HUNT;
            ones_r <= 4'h0;
            bn_r <= 4'h0;
            sh_r <= 10'h0;
            n_r <= 3'h0;
            vld_r <= 1'b0;
            perr_r <= 1'b0;
            hdr_r <= 8'h00;
            m0_r <= 8'h00;
            m1_r <= 8'h00;
            for (int k = 0; k < 4; k++)
                b_r[k] <= 8'h00;
        end
        else
        begin
            prev_r <= link.load_mod;
            vld_r <= 1'b0;
            perr_r <= 1'b0;
            gap_r <= edge_w ? 24'h0 : (gap_r == 24'hffffff ? gap_r : gap_r + 24'h1);
            if (edge_w)
                half_r <= !idle_w && bval && !half_r;
            if (ps_r == wrx_pkg::P_GAP && idle_w && !edge_w)
            begin
                ps_r <= wrx_pkg::P_HUNT;
                ones_r <= 4'h0;
                n_r <= 3'h0;
                if (n_r >= 3'd3 && (b_r[0] ^ b_r[1] ^ b_r[2] ^ b_r[3]) == 8'h00)
                begin
                    vld_r <= 1'b1;
                    hdr_r <= b_r[0];
                    m0_r <= b_r[1];
                    m1_r <= (n_r == 3'd4) ? b_r[2] : 8'h00;
                end
                else
                    perr_r <= 1'b1;
            end
            else if (ps_r == wrx_pkg::P_DATA && idle_w)
            begin
                ps_r <= wrx_pkg::P_HUNT;
                perr_r <= 1'b1;
                n_r <= 3'h0;
            end
            else if (bev)
            begin
                unique case (ps_r)
                    wrx_pkg::P_HUNT:
                        if (bval)
                            ones_r <= (ones_r == 4'hf) ? ones_r : ones_r + 4'h1;
                        else if (ones_r >= 4'd4)
                        begin
                            ps_r <= wrx_pkg::P_DATA;
                            bn_r <= 4'h0;
                            for (int k = 0; k < 4; k++)
                                b_r[k] <= 8'h00;
                        end
                        else
                            ones_r <= 4'h0;
                    wrx_pkg::P_DATA:
                    begin
                        sh_r <= {bval, sh_r[9:1]};
                        bn_r <= bn_r + 4'h1;
                        if (bn_r == 4'd9)
                        begin
                            if (!bval || ^sh_r[9:1] == 1'b0 || n_r == 3'd4)
                            begin
                                ps_r <= wrx_pkg::P_HUNT;
                                perr_r <= 1'b1;
                                n_r <= 3'h0;
                            end
                            else
                            begin
                                b_r[n_r[1:0]] <= sh_r[8:1];
                                n_r <= n_r + 3'h1;
                                ps_r <= wrx_pkg::P_GAP;
                            end
                        end
                    end
                    wrx_pkg::P_GAP:
                        if (!bval)
                        begin
                            ps_r <= wrx_pkg::P_DATA;
                            bn_r <= 4'h0;
                        end
                endcase
            end
        end
    end

    // Coil control: sleep, ping, and power only after identification.
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            ts_r <= wrx_pkg::T_OFF;
            tmr_r <= 26'(OFF_CYC - 1);
            step_r <= 2'h0;
        end
        else if (vld_r && hdr_r == `WRX_HDR_EPT)
        begin
            ts_r <= wrx_pkg::T_OFF;
            tmr_r <= 26'(OFF_CYC - 1);
        end
        else
        begin
            unique case (ts_r)
                wrx_pkg::T_OFF:
                    if (tmr_r == 26'h0)
                    begin
                        ts_r <= wrx_pkg::T_PING; // RULE16
                        tmr_r <= 26'(PING_CYC - 1);
                        step_r <= 2'h0;
                    end
                    else
                        tmr_r <= tmr_r - 26'h1;
                wrx_pkg::T_PING:
                    if (vld_r)
                    begin
                        tmr_r <= 26'(PING_CYC - 1);
                        if ((step_r == 2'd0 && hdr_r == `WRX_HDR_SS)
                            || (step_r == 2'd1 && hdr_r == `WRX_HDR_CFG))
                            step_r <= step_r + 2'h1;
                        else if (step_r == 2'd2 && hdr_r == `WRX_HDR_ID)
                            ts_r <= wrx_pkg::T_PWR; // RULE5 RULE16
                        else
                        begin
                            ts_r <= wrx_pkg::T_OFF;
                            tmr_r <= 26'(OFF_CYC - 1);
                        end
                    end
                    else if (tmr_r == 26'h0)
                    begin
                        ts_r <= wrx_pkg::T_OFF;
                        tmr_r <= 26'(OFF_CYC - 1);
                    end
                    else
                        tmr_r <= tmr_r - 26'h1;
                wrx_pkg::T_PWR:
                    tmr_r <= 26'h0;
            endcase
        end
    end
endmodule : wrx_tx_end
`default_nettype wire

// ### testbench/wireless_rx_power_control_link_bench.sv
// Bench joining receiver and pad ends over the link.
`timescale 1ns/100ps
`default_nettype none
module wireless_rx_power_control_link_bench;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic msa = 1'b0, msb = 1'b0, flt = 1'b0, ad = 1'b0, oe, otg, rxc, txc, pv, pe;
    logic [1:0] tmp = 2'h0;
    logic [14:0] rv = 15'h1b58, rt;
    logic [11:0] oc = 12'h032, cl, rps = 12'h800, ils = 12'h064;
    logic [19:0] kg = 20'h186a0;
    logic [7:0] ph, p0;
    int num_errors = 0, num_checks = 0;
    logic [11:0] cur [4] = '{12'h032, 12'h096, 12'h12c, 12'h1f4};
    logic [14:0] tgt [4] = '{15'h1ba8, 15'h1888, 15'h159a, 15'h13f6};
    logic [4:0] cnd [4] = '{5'h18, 5'h10, 5'h04, 5'h02};
    logic [7:0] rsn [4] = '{8'h01, 8'h00, 8'h02, 8'h03};
    logic [7:0] hdr [3] = '{8'h01, 8'h51, 8'h71};
    wrx_link_if link();
    wrx_rx_end #(.HALF_CYC(8), .FAST_CYC(1000), .SLOW_CYC(3000)) i_wrx_rx_end (
        .clk_sys(clk_sys), .srst(srst), .link(link), .mode_select_a(msa),
        .mode_select_b(msb), .adapter_present(ad), .temp_ctrl_input(tmp),
        .internal_fault(flt), .rectified_voltage(rv), .out_current(oc),
        .received_power_sense(rps), .max_current_gain(kg),
        .current_limit_set(ils), .out_enable(oe), .otg_enable(otg), .contract(rxc),
        .comm_limit_on(), .comm_limit_ma(cl), .rect_target(rt));
    wrx_tx_end #(.HALF_CYC(8), .OFF_CYC(50)) i_wrx_tx_end (
        .clk_sys(clk_sys), .srst(srst), .link(link), .coil_on(), .contract(txc),
        .pkt_valid(pv), .pkt_err(pe), .pkt_hdr(ph), .pkt_m0(p0), .pkt_m1());
    wrx_link_assertions i_chk (.clk_sys(clk_sys), .srst(srst), .ping(link.ping),
        .load_mod(link.load_mod));
    initial forever #4 clk_sys = ~clk_sys;
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task wait_pkt;
        int n;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            #1;
            n++;
        end while (pv !== 1'b1 && n < 30000);
        if (n >= 30000) chk(16'h0, 16'h1);
    endtask : wait_pkt
    always @(posedge clk_sys) if (pe === 1'b1) chk(16'h1, 16'h0);
    always @(posedge clk_sys) if (pv === 1'b1 && ph === 8'h04) chk(p0, rps[11:4]);
    task t_start;
        chk(txc, 1'b0);
        for (int k = 0; k < 3; k++)
        begin
            wait_pkt();
            chk(ph, hdr[k]);
        end
        wait_pkt();
        chk(ph, 8'h03);
        chk(txc, 1'b1);
        chk(rxc, 1'b1);
        chk(rt, 15'h1ba8);
        chk(oe, 1'b0);
        chk(cl, 12'h190);
    endtask : t_start
    task t_band;
        rv = 15'h1bbc;
        for (int k = 0; k < 4; k++)
        begin
            oc = cur[k];
            repeat (3) wait_pkt();
            chk(oe, 1'b1);
            chk(rt, tgt[k]);
        end
        chk(cl, 12'h226);
    endtask : t_band
    task t_stop;
        for (int k = 0; k < 4; k++)
        begin
            {msa, msb, flt, tmp} = cnd[k];
            wait_pkt();
            while (k == 0 && ph !== 8'h02 && num_errors == 0) wait_pkt();
            chk(ph, 8'h02);
            chk(p0, rsn[k]);
            if (k == 1) chk(otg, 1'b1);
        end
        {ad, tmp} = 3'h4;
        wait_pkt();
        chk(p0, 8'h00);
    endtask : t_stop
    task print_verdict;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : print_verdict
    initial
    begin
        #640000;
        num_errors++;
        print_verdict();
    end
    initial
    begin
        repeat (20) @(posedge clk_sys);
        #1;
        srst = 1'b0;
        t_start();
        t_band();
        t_stop();
        print_verdict();
    end
endmodule : wireless_rx_power_control_link_bench
`default_nettype wire

// ### testbench/wrx_link_assertions.sv
// Assertions on the load modulation link wires.
`timescale 1ns/100ps
`default_nettype none
module wrx_link_assertions (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic ping,
    input wire logic load_mod
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (srst);
    property p_half_min;
        $changed(load_mod) |=> $stable(load_mod) [*7];
    endproperty
    a_half_min: assert property (p_half_min) else $error("half bit short");
    property p_answer;
        $rose(ping) |-> ##[2:4] $changed(load_mod);
    endproperty
    a_answer: assert property (p_answer) else $error("no answer to ping");
    property p_preamble;
        $rose(ping) |-> ##[9:13] $changed(load_mod);
    endproperty
    a_preamble: assert property (p_preamble) else $error("no second toggle");
    property p_ping_hold;
        $rose(ping) |=> ping [*8];
    endproperty
    a_ping_hold: assert property (p_ping_hold) else $error("ping too short");
    property p_off_time;
        $fell(srst) |-> !ping [*8];
    endproperty
    a_off_time: assert property (p_off_time) else $error("coil on early");
    property p_mod_quiet;
        $fell(srst) |-> !load_mod [*8];
    endproperty
    a_mod_quiet: assert property (p_mod_quiet) else $error("load on early");
    property p_quiet;
        !ping && !$past(ping) && !$past(ping, 2) |-> $stable(load_mod);
    endproperty
    a_quiet: assert property (p_quiet) else $error("load moves unpowered");
    property p_powered;
        $changed(load_mod) |-> ping || $past(ping) || $past(ping, 2);
    endproperty
    a_powered: assert property (p_powered) else $error("toggle without ping");
    c_ping: cover property ($rose(ping));
    c_drop: cover property ($fell(ping));
    c_tog: cover property ($changed(load_mod));
endmodule : wrx_link_assertions
`default_nettype wire
